// ===== common/vcm_pkg.sv
// Constants and types for the oscillator calibration and monitor configuration bank.
// Assumes byte-wide register access at the printed offsets on one 100 MHz clock.
package vcm_pkg;

  localparam int VCM_ADDR_W   = 12;
  localparam int VCM_DATA_W   = 8;
  localparam int VCM_NUM_REGS = 9;
  localparam int VCM_IDX_W    = 4;

  // Printed offsets
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_WAIT_LOW     = 12'h031;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_MON_CTRL     = 12'h032;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_READBACK     = 12'h033;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_OVERRIDE     = 12'h034;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_MON_DIV      = 12'h035;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_PUMP_TRIM    = 12'h036;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_MANUAL_BAND  = 12'h037;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_MANUAL_CORE  = 12'h038;
  localparam logic [VCM_ADDR_W-1:0] VCM_OFS_TEST_TUNE    = 12'h039;

  // Array index of each register, counted from the lowest offset
  localparam int VCM_IDX_WAIT_LOW    = 0;
  localparam int VCM_IDX_MON_CTRL    = 1;
  localparam int VCM_IDX_READBACK    = 2;
  localparam int VCM_IDX_OVERRIDE    = 3;
  localparam int VCM_IDX_MON_DIV     = 4;
  localparam int VCM_IDX_PUMP_TRIM   = 5;
  localparam int VCM_IDX_MANUAL_BAND = 6;
  localparam int VCM_IDX_MANUAL_CORE = 7;
  localparam int VCM_IDX_TEST_TUNE   = 8;

  // Reset values, index 8 first
  localparam logic [VCM_NUM_REGS-1:0][7:0] VCM_REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Writable bits; bit 7 of the test and tune register is read-only
  localparam logic [VCM_NUM_REGS-1:0][7:0] VCM_REG_WMASK = {
    8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Field positions
  localparam int VCM_MON_INPUT_SEL_BIT = 7;
  localparam int VCM_MON_FAST_BIT      = 5;
  localparam int VCM_MON_REPEAT_BIT    = 4;
  localparam int VCM_MON_CONVERT_BIT   = 3;
  localparam int VCM_MON_POWER_BIT     = 2;
  localparam int VCM_WAIT_HI_MSB       = 1;
  localparam int VCM_WAIT_HI_LSB       = 0;
  localparam int VCM_READBACK_MSB      = 7;
  localparam int VCM_READBACK_LSB      = 5;
  localparam int VCM_SETTLE_MSB        = 4;
  localparam int VCM_SETTLE_LSB        = 0;
  localparam int VCM_OVR_MODE_MSB      = 7;
  localparam int VCM_OVR_MODE_LSB      = 5;
  localparam int VCM_LEVEL_WAIT_MSB    = 4;
  localparam int VCM_LEVEL_WAIT_LSB    = 0;
  localparam int VCM_CORE_MSB          = 7;
  localparam int VCM_CORE_LSB          = 4;
  localparam int VCM_TEST_ROUTE_MSB    = 6;
  localparam int VCM_TEST_ROUTE_LSB    = 4;
  localparam int VCM_TUNE_MSB          = 3;
  localparam int VCM_TUNE_LSB          = 0;

  // Monitor clock period in detector ticks is divisor * MUL + ADD
  localparam logic [10:0] VCM_MON_DIV_MUL = 11'h004;
  localparam logic [10:0] VCM_MON_DIV_ADD = 11'h002;

  // Tuning target in millivolts is BASE + code * STEP
  localparam logic [11:0] VCM_TUNE_BASE_MV = 12'h244;
  localparam logic [11:0] VCM_TUNE_STEP_MV = 12'h096;

  // Pattern returned in checkerboard readback
  localparam logic [15:0] VCM_CHECKER_PATTERN = 16'hAA55;

  typedef enum logic [2:0] {
    VCM_OVR_NORMAL           = 3'b000,
    VCM_OVR_MANUAL_CORE_BAND = 3'b010,
    VCM_OVR_MANUAL_VOLTAGE   = 3'b100
  } vcm_override_mode_t;

  typedef enum logic [2:0] {
    VCM_RB_CHECKER   = 3'b000,
    VCM_RB_CORE_BAND = 3'b001,
    VCM_RB_MONITOR   = 3'b101
  } vcm_readback_sel_t;

endpackage : vcm_pkg

// ===== hw/vcm_monclk_div.sv
// Monitor converter clock divider driven by detector-rate ticks.
// Assumes pfd_tick is a one-cycle pulse at the detector frequency.
module vcm_monclk_div (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       pfd_tick,
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  // Divided clock level
  output      logic       mon_clk
);
  import vcm_pkg::*;

  typedef struct packed {
    logic [9:0] cnt;
    logic       lvl;
  } vcm_div_state_t;

  vcm_div_state_t st_reg;
  vcm_div_state_t st_next;
  logic [10:0]    period;

  // Half period toggling gives a full period of divisor*4+2 ticks
  assign period = 11'(divisor) * VCM_MON_DIV_MUL + VCM_MON_DIV_ADD;

  always_comb begin
    st_next = st_reg;
    if (!run) begin
      st_next = '0;
    end else if (pfd_tick) begin
      if (st_reg.cnt == period[10:1] - 10'h001) begin
        st_next.cnt = 10'h000;
        st_next.lvl = ~st_reg.lvl;
      end else begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mon_clk = st_reg.lvl;

endmodule : vcm_monclk_div

// ===== hw/vcm_cal_select.sv
// Chooses the oscillator core and band between calibration result and manual values.
// Assumes the calibration engine presents its result as steady levels.
module vcm_cal_select (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Configuration
  input  wire logic [2:0] mode,
  input  wire logic [3:0] manual_core_value,
  input  wire logic [7:0] manual_band_value,
  // Calibration result
  input  wire logic [3:0] auto_core,
  input  wire logic [7:0] auto_band,
  // Selected values
  output      logic [3:0] osc_core_sel,
  output      logic [7:0] osc_band_sel,
  output      logic       manual_voltage_en
);
  import vcm_pkg::*;

  typedef struct packed {
    logic [3:0] core;
    logic [7:0] band;
    logic       man_v;
  } vcm_sel_state_t;

  vcm_sel_state_t st_reg;
  vcm_sel_state_t st_next;

  always_comb begin
    st_next.core  = auto_core;
    st_next.band  = auto_band;
    st_next.man_v = 1'b0;
    case (vcm_override_mode_t'(mode))
      VCM_OVR_NORMAL: begin
        st_next.man_v = 1'b0;
      end
      VCM_OVR_MANUAL_CORE_BAND: begin
        st_next.core = manual_core_value;
        st_next.band = manual_band_value;
      end
      VCM_OVR_MANUAL_VOLTAGE: begin
        st_next.man_v = 1'b1;
      end
      // Undefined codes fall back to normal calibration
      default: begin
        st_next.man_v = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign osc_core_sel      = st_reg.core;
  assign osc_band_sel      = st_reg.band;
  assign manual_voltage_en = st_reg.man_v;

endmodule : vcm_cal_select

// ===== hw/vcm_regs.sv
// Configuration bank for oscillator autocalibration and the monitor converter.
// Assumes the serial port front end delivers decoded byte accesses synchronous to ref_clk.
module vcm_regs (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  // Register access
  input  wire logic [vcm_pkg::VCM_ADDR_W-1:0] reg_addr,
  input  wire logic                    reg_wr_en,
  input  wire logic [vcm_pkg::VCM_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_rd_en,
  output      logic [vcm_pkg::VCM_DATA_W-1:0] reg_rdata,
  output      logic                    reg_rd_valid,
  // Calibration engine and converter status
  input  wire logic [3:0]              auto_core,
  input  wire logic [7:0]              auto_band,
  input  wire logic [7:0]              monitor_result,
  // Detector timing and clock gating
  input  wire logic                    pfd_tick,
  input  wire logic                    monitor_clk_disable,
  // Monitor converter control
  output      logic                    monitor_input_sel,
  output      logic                    monitor_power_on,
  output      logic                    monitor_convert_req,
  output      logic                    monitor_convert_start,
  output      logic                    monitor_repeat_mode,
  output      logic                    monitor_fast_mode,
  output      logic                    monitor_clk,
  // Calibration timing
  output      logic [9:0]              cal_wait_count,
  output      logic [4:0]              synth_settle_count,
  output      logic [4:0]              osc_level_wait,
  // Calibration override
  output      logic [2:0]              cal_override_mode,
  output      logic [3:0]              osc_core_sel,
  output      logic [7:0]              osc_band_sel,
  output      logic                    manual_voltage_en,
  // Tuning target and test routing
  output      logic [3:0]              tune_target_select,
  output      logic [11:0]             tune_target_mv,
  output      logic [2:0]              test_route_select,
  output      logic [7:0]              pump_offset_trim,
  // Readback to the calibration engine
  output      logic [15:0]             cal_readback_data
);
  import vcm_pkg::*;

  typedef struct packed {
    logic [VCM_NUM_REGS-1:0][7:0] regs;
    logic [7:0]                   rdata;
    logic                         rd_valid;
    logic [15:0]                  readback;
    logic [11:0]                  tune_mv;
    logic                         conv_prev;
    logic                         conv_start;
    logic                         clk_run;
  } vcm_regs_state_t;

  localparam vcm_regs_state_t VCM_STATE_RESET = '{
    regs:       VCM_REG_RESET,
    rdata:      8'h00,
    rd_valid:   1'b0,
    readback:   16'h0000,
    tune_mv:    12'h000,
    conv_prev:  1'b0,
    conv_start: 1'b0,
    clk_run:    1'b0
  };

  vcm_regs_state_t         st_reg;
  vcm_regs_state_t         st_next;
  logic [VCM_ADDR_W-1:0]   addr_off;
  logic [VCM_IDX_W-1:0]    idx;
  logic                    hit;
  logic [7:0]              ctrl_q;
  logic [7:0]              rb_q;
  logic [7:0]              ovr_q;
  logic [7:0]              tt_q;
  logic                    conv_now;
  logic [3:0]              core_sel_w;
  logic [7:0]              band_sel_w;
  logic                    man_v_w;
  logic                    mon_clk_w;

  // Decode: the bank is one contiguous run of byte registers
  assign addr_off = reg_addr - VCM_OFS_WAIT_LOW;
  assign idx      = addr_off[VCM_IDX_W-1:0];
  assign hit      = (reg_addr >= VCM_OFS_WAIT_LOW) && (reg_addr <= VCM_OFS_TEST_TUNE);

  assign ctrl_q = st_reg.regs[VCM_IDX_MON_CTRL];
  assign rb_q   = st_reg.regs[VCM_IDX_READBACK];
  assign ovr_q  = st_reg.regs[VCM_IDX_OVERRIDE];
  assign tt_q   = st_reg.regs[VCM_IDX_TEST_TUNE];

  // A conversion is only meaningful while the converter is powered
  assign conv_now = ctrl_q[VCM_MON_CONVERT_BIT] & ctrl_q[VCM_MON_POWER_BIT];

  always_comb begin
    st_next            = st_reg;
    st_next.rd_valid   = 1'b0;
    st_next.conv_start = 1'b0;

    // Masked write keeps read-only bits at their reset value
    if (reg_wr_en && hit) begin
      st_next.regs[idx] = (reg_wdata & VCM_REG_WMASK[idx])
                        | (st_reg.regs[idx] & ~VCM_REG_WMASK[idx]);
    end

    // Reads return the value held before any same-cycle write
    if (reg_rd_en) begin
      st_next.rd_valid = 1'b1;
      st_next.rdata    = hit ? st_reg.regs[idx] : 8'h00;
    end

    // One pulse per request; repeat mode is left to the converter
    st_next.conv_prev  = conv_now;
    st_next.conv_start = conv_now & ~st_reg.conv_prev;

    // Enable wins over the separate disable
    st_next.clk_run = ctrl_q[VCM_MON_POWER_BIT] | ~monitor_clk_disable;

    case (vcm_readback_sel_t'(rb_q[VCM_READBACK_MSB:VCM_READBACK_LSB]))
      VCM_RB_CHECKER: begin
        st_next.readback = VCM_CHECKER_PATTERN;
      end
      VCM_RB_CORE_BAND: begin
        st_next.readback = {4'h0, core_sel_w, band_sel_w};
      end
      VCM_RB_MONITOR: begin
        st_next.readback = {8'h00, monitor_result};
      end
      // Other codes return zero rather than stale data
      default: begin
        st_next.readback = 16'h0000;
      end
    endcase

    st_next.tune_mv = VCM_TUNE_BASE_MV
                    + 12'(tt_q[VCM_TUNE_MSB:VCM_TUNE_LSB]) * VCM_TUNE_STEP_MV;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= VCM_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  vcm_monclk_div u_monclk_div (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .pfd_tick (pfd_tick),
    .run      (st_reg.clk_run),
    .divisor  (st_reg.regs[VCM_IDX_MON_DIV]),
    .mon_clk  (mon_clk_w)
  );

  vcm_cal_select u_cal_select (
    .ref_clk           (ref_clk),
    .resetn            (resetn),
    .mode              (ovr_q[VCM_OVR_MODE_MSB:VCM_OVR_MODE_LSB]),
    .manual_core_value (st_reg.regs[VCM_IDX_MANUAL_CORE][VCM_CORE_MSB:VCM_CORE_LSB]),
    .manual_band_value (st_reg.regs[VCM_IDX_MANUAL_BAND]),
    .auto_core         (auto_core),
    .auto_band         (auto_band),
    .osc_core_sel      (core_sel_w),
    .osc_band_sel      (band_sel_w),
    .manual_voltage_en (man_v_w)
  );

  // Register access answers
  assign reg_rdata    = st_reg.rdata;
  assign reg_rd_valid = st_reg.rd_valid;

  // Converter control
  assign monitor_input_sel     = ctrl_q[VCM_MON_INPUT_SEL_BIT];
  assign monitor_power_on      = ctrl_q[VCM_MON_POWER_BIT];
  assign monitor_convert_req   = ctrl_q[VCM_MON_CONVERT_BIT];
  assign monitor_convert_start = st_reg.conv_start;
  assign monitor_repeat_mode   = ctrl_q[VCM_MON_REPEAT_BIT];
  assign monitor_fast_mode     = ctrl_q[VCM_MON_FAST_BIT];
  assign monitor_clk           = mon_clk_w;

  // Timing fields
  assign cal_wait_count = {ctrl_q[VCM_WAIT_HI_MSB:VCM_WAIT_HI_LSB],
                           st_reg.regs[VCM_IDX_WAIT_LOW]};
  assign synth_settle_count = rb_q[VCM_SETTLE_MSB:VCM_SETTLE_LSB];
  // Passed through unchanged; software is expected to leave it zero
  assign osc_level_wait = ovr_q[VCM_LEVEL_WAIT_MSB:VCM_LEVEL_WAIT_LSB];

  // Override
  assign cal_override_mode = ovr_q[VCM_OVR_MODE_MSB:VCM_OVR_MODE_LSB];
  assign osc_core_sel      = core_sel_w;
  assign osc_band_sel      = band_sel_w;
  assign manual_voltage_en = man_v_w;

  // Tuning target and test routing
  assign tune_target_select = tt_q[VCM_TUNE_MSB:VCM_TUNE_LSB];
  assign tune_target_mv     = st_reg.tune_mv;
  assign test_route_select  = tt_q[VCM_TEST_ROUTE_MSB:VCM_TEST_ROUTE_LSB];
  assign pump_offset_trim   = st_reg.regs[VCM_IDX_PUMP_TRIM];
  assign cal_readback_data  = st_reg.readback;

endmodule : vcm_regs

// ===== dv/vcm_regs_chk.sv
// Checker for the calibration and monitor register bank.
// Bound to vcm_regs; watches its ports only, one clock domain.
module vcm_regs_chk
  import vcm_pkg::*;
(
  // Clock and reset
  input wire logic                            ref_clk,
  input wire logic                            resetn,
  // Register access
  input wire logic [vcm_pkg::VCM_ADDR_W-1:0] reg_addr,
  input wire logic                            reg_wr_en,
  input wire logic [vcm_pkg::VCM_DATA_W-1:0] reg_wdata,
  // Status and gating
  input wire logic [3:0]                      auto_core,
  input wire logic [7:0]                      auto_band,
  input wire logic                            monitor_clk_disable,
  // Watched outputs
  input wire logic                            monitor_input_sel,
  input wire logic                            monitor_power_on,
  input wire logic                            monitor_convert_req,
  input wire logic                            monitor_convert_start,
  input wire logic                            monitor_repeat_mode,
  input wire logic                            monitor_fast_mode,
  input wire logic                            monitor_clk,
  input wire logic [9:0]                      cal_wait_count,
  input wire logic [4:0]                      synth_settle_count,
  input wire logic [2:0]                      cal_override_mode,
  input wire logic [3:0]                      osc_core_sel,
  input wire logic [7:0]                      osc_band_sel,
  input wire logic                            manual_voltage_en,
  input wire logic [3:0]                      tune_target_select,
  input wire logic [11:0]                     tune_target_mv
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire w31 = reg_wr_en && reg_addr == VCM_OFS_WAIT_LOW;
  wire w32 = reg_wr_en && reg_addr == VCM_OFS_MON_CTRL;
  wire w33 = reg_wr_en && reg_addr == VCM_OFS_READBACK;
  wire w34 = reg_wr_en && reg_addr == VCM_OFS_OVERRIDE;

  input_sel_a: assert property (w32 |=> monitor_input_sel == $past(reg_wdata[7]))
    else $error("monitor input select does not follow write");
  ctrl_bits_a: assert property (w32 |=> {monitor_fast_mode, monitor_repeat_mode,
    monitor_convert_req, monitor_power_on} == $past(reg_wdata[5:2]))
    else $error("converter control bits do not follow write");
  start_pulse_a: assert property ($rose(monitor_convert_req && monitor_power_on)
    |=> monitor_convert_start ##1 !monitor_convert_start)
    else $error("conversion start pulse missing or too long");
  wait_hi_a: assert property (w32 |=> cal_wait_count[9:8] == $past(reg_wdata[1:0]))
    else $error("wait count high bits wrong");
  wait_lo_a: assert property (w31 |=> cal_wait_count[7:0] == $past(reg_wdata))
    else $error("wait count low byte wrong");
  settle_cnt_a: assert property (w33 |=> synth_settle_count == $past(reg_wdata[4:0]))
    else $error("settle count wrong");
  ovr_mode_a: assert property (w34 |=> cal_override_mode == $past(reg_wdata[7:5]))
    else $error("override mode wrong");
  volt_en_a: assert property (w34 && reg_wdata[7:5] == 3'b100 |=> ##1 manual_voltage_en)
    else $error("manual voltage enable missing");
  auto_pass_a: assert property ($past(resetn) && cal_override_mode == 3'b000
    |=> osc_core_sel == $past(auto_core) && osc_band_sel == $past(auto_band))
    else $error("normal mode does not pass calibration result");
  manual_hold_a: assert property ((cal_override_mode == 3'b010 && !reg_wr_en) [*2]
    |=> $stable(osc_core_sel) && $stable(osc_band_sel))
    else $error("manual core or band not held");
  tune_mv_a: assert property ($past(resetn) |-> tune_target_mv ==
    VCM_TUNE_BASE_MV + VCM_TUNE_STEP_MV * $past(tune_target_select))
    else $error("tuning target voltage wrong");
  clk_off_a: assert property ((!monitor_power_on && monitor_clk_disable) [*4]
    |-> !monitor_clk)
    else $error("monitor clock runs while disabled and off");
endmodule : vcm_regs_chk

bind vcm_regs vcm_regs_chk u_chk (.*);

// ===== dv/vcm_regs_tb_top.sv
// Self-checking bench for the calibration and monitor register bank.
// Drives the byte access port directly; detector ticks are made here.
module vcm_regs_tb_top;
  import vcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        resetn, reg_wr_en, reg_rd_en, pfd_tick, monitor_clk_disable, tick_on;
  logic [11:0] reg_addr, tune_target_mv;
  logic [7:0]  reg_wdata, reg_rdata, auto_band, monitor_result, osc_band_sel, pump_offset_trim;
  logic        reg_rd_valid, monitor_input_sel, monitor_power_on, monitor_convert_req;
  logic        monitor_convert_start, monitor_repeat_mode, monitor_fast_mode, monitor_clk;
  logic        manual_voltage_en;
  logic [3:0]  auto_core, osc_core_sel, tune_target_select;
  logic [9:0]  cal_wait_count;
  logic [4:0]  synth_settle_count, osc_level_wait;
  logic [2:0]  cal_override_mode, test_route_select, m;
  logic [15:0] cal_readback_data;
  int          bad_count = 0;
  int          cmp_count = 0;

  vcm_regs DUT (.*);
  always #5 ref_clk = ~ref_clk;
  // One-cycle detector pulse every second clock
  always @(posedge ref_clk) pfd_tick <= tick_on & ~pfd_tick;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    #1;
  endtask : wr

  // Answer is registered on the taking edge and checked 1 ns after it
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("rd_valid", 16'h0001, 16'(reg_rd_valid));
    chk($sformatf("reg %h", a), 16'(exp), 16'(reg_rdata));
  endtask : rd

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  // Clock cycles between two successive monitor clock edges
  task automatic half_period(input int exp);
    int  n;
    logic last;
    for (int k = 0; k < 2; k++) begin
      last = monitor_clk;
      for (n = 0; n < 400 && monitor_clk === last; n++) step();
      if (n >= 400) begin
        bad_count++;
        end_of_test();
      end
    end
    chk("mon_clk half period", 16'(exp), 16'(n));
  endtask : half_period

  initial begin
    resetn = 1'b0;
    {reg_wr_en, reg_rd_en, tick_on} = 3'h0;
    {reg_addr, reg_wdata} = 20'h00000;
    auto_core = 4'h6;
    auto_band = 8'h81;
    monitor_result = 8'h3C;
    monitor_clk_disable = 1'b1;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < VCM_NUM_REGS; i++) rd(12'(VCM_OFS_WAIT_LOW + i), VCM_REG_RESET[i]);
    for (int i = 0; i < VCM_NUM_REGS; i++) begin
      wr(12'(VCM_OFS_WAIT_LOW + i), 8'(8'hA5 ^ i));
      rd(12'(VCM_OFS_WAIT_LOW + i), 8'((8'hA5 ^ i) & VCM_REG_WMASK[i]));
    end
    chk("pump trim", 16'h00A0, 16'(pump_offset_trim));
    wr(12'h03A, 8'hFF);
    rd(12'h03A, 8'h00);
    rd(12'h030, 8'h00);
    wr(VCM_OFS_WAIT_LOW, 8'h5A);
    wr(VCM_OFS_MON_CTRL, 8'h8E);
    chk("wait count", 16'h025A, 16'(cal_wait_count));
    chk("input sel", 16'h0001, 16'(monitor_input_sel));
    chk("ctrl bits", 16'h0003, 16'({monitor_fast_mode, monitor_repeat_mode, monitor_convert_req, monitor_power_on}));
    step();
    chk("conv start", 16'h0001, 16'(monitor_convert_start));
    step();
    chk("conv start", 16'h0000, 16'(monitor_convert_start));
    wr(VCM_OFS_MON_CTRL, 8'h30);
    chk("ctrl bits", 16'h000C, 16'({monitor_fast_mode, monitor_repeat_mode, monitor_convert_req, monitor_power_on}));
    chk("wait count", 16'h005A, 16'(cal_wait_count));
    wr(VCM_OFS_OVERRIDE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 3'b000 : (i == 1) ? 3'b001 : (i == 2) ? 3'b101 : 3'b011;
      wr(VCM_OFS_READBACK, {m, 5'h1F});
      step();
      chk("readback", (i == 0) ? 16'hAA55 : (i == 1) ? 16'h0681 : (i == 2) ? 16'h003C : 16'h0000, cal_readback_data);
      chk("settle", 16'h001F, 16'(synth_settle_count));
    end
    wr(VCM_OFS_MANUAL_BAND, 8'hC3);
    wr(VCM_OFS_MANUAL_CORE, 8'h9F);
    for (int i = 0; i < 4; i++) begin
      m = 3'(2 * i);
      wr(VCM_OFS_OVERRIDE, {m, 5'h00});
      step();
      chk("ovr mode", 16'(m), 16'(cal_override_mode));
      chk("level wait", 16'h0000, 16'(osc_level_wait));
      chk("core sel", (m == 3'b010) ? 16'h0009 : 16'h0006, 16'(osc_core_sel));
      chk("band sel", (m == 3'b010) ? 16'h00C3 : 16'h0081, 16'(osc_band_sel));
      chk("volt en", 16'(m == 3'b100), 16'(manual_voltage_en));
    end
    wr(VCM_OFS_OVERRIDE, 8'h40);
    @(posedge ref_clk);
    auto_core <= 4'h2;
    auto_band <= 8'h18;
    repeat (2) step();
    chk("core band", 16'h09C3, 16'({osc_core_sel, osc_band_sel}));
    wr(VCM_OFS_OVERRIDE, 8'h00);
    step();
    chk("core band", 16'h0218, 16'({osc_core_sel, osc_band_sel}));
    for (int c = 0; c < 16; c++) begin
      wr(VCM_OFS_TEST_TUNE, {4'hD, 4'(c)});
      step();
      chk("tune mv", 16'(VCM_TUNE_BASE_MV + VCM_TUNE_STEP_MV * c), 16'(tune_target_mv));
      chk("tune route", 16'(8'h50 + c), 16'({test_route_select, tune_target_select}));
    end
    wr(VCM_OFS_MON_DIV, 8'h00);
    wr(VCM_OFS_MON_CTRL, 8'h04);
    @(posedge ref_clk);
    tick_on <= 1'b1;
    half_period(2);
    wr(VCM_OFS_MON_DIV, 8'h02);
    half_period(10);
    wr(VCM_OFS_MON_CTRL, 8'h00);
    repeat (8) step();
    chk("mon_clk stopped", 16'h0000, 16'(monitor_clk));
    @(posedge ref_clk);
    monitor_clk_disable <= 1'b0;
    half_period(10);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(VCM_OFS_MON_DIV, 8'h00);
    end_of_test();
  end
endmodule : vcm_regs_tb_top
